// ==== src/smc_classifier.sv ====
// first-stage speech/music classifier behind a wishbone slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - each feature is multiplied by its gain and offset added.
// - wideband or narrowband gain/offset set chosen from the constant table.
// - per class, sum exp(constant minus half quadratic distance) over six parts.
// - class log-likelihood is log of sum minus half log((2pi)^12).
// - speech, music, noise scores; inactive frames use 1.2 times noise.
// - raw margin is music minus speech, then recursively smoothed.
// - energy weight is one plus energy/15, clamped to 0.01..1.
// - drop accumulator loads or grows on falling negative margin, else zero.
// - drop weight is accumulator/20, clamped to 0.1..1.
// - combined factor is energy weight times drop weight, at least 0.01.
// - counter starts at zero, state at -8, state kept in -8..+8.
// - active state is entered only from the entry state.
// - smoothed margin is forced to zero while state is -8.
// - music flag cleared when inactive and activity flag is low.
// - state from -7 to zero after active holds previous flag.
// - entry sum weights the eight latest raw margins by state row.
// - fixed lower-triangular eight-by-eight entry weight table.
// - in entry state the flag follows entry sum above two.
// - active state sets flag on positive smoothing after three speech frames.
// - active state clears flag on negative smoothing after a music frame.
module smc_classifier (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_wb_cyc,
    input  wire logic                       i_wb_stb,
    input  wire logic                       i_wb_we,
    input  wire logic [smc_pkg::BUS_AW-1:0] i_wb_adr,
    input  wire logic [3:0]                 i_wb_sel,
    input  wire logic [31:0]                i_wb_dat,
    output logic      [31:0]                o_wb_dat,
    output logic                            o_wb_ack,
    output logic                            o_music_flag,
    output logic                            o_frame_done
);
    import smc_pkg::*;

    function automatic smc_q_t sat(input logic signed [63:0] v);
        if (v > Q_MAX) return Q_MAX[W-1:0];
        if (v < Q_MIN) return Q_MIN[W-1:0];
        return v[W-1:0];
    endfunction

    function automatic logic signed [63:0] mulq(input smc_q_t a,
                                                input smc_q_t b);
        logic signed [47:0] p;
        p = a * b;
        return 64'(p >>> FRAC);
    endfunction

    logic               wideband;
    logic               hi_eff;
    smc_q_t             energy;
    smc_q_t             feat [NFEAT];
    smc_q_t             mem [MEM_WORDS];
    smc_phase_t         phase;
    logic [1:0]         ci;
    logic [2:0]         ck;
    logic [3:0]         fi;
    logic [3:0]         fj;
    logic [MEM_AW-1:0]  ptr;
    smc_q_t             fs [NFEAT];
    smc_q_t             dvec [NFEAT];
    logic signed [63:0] tacc;
    logic signed [63:0] qacc;
    smc_q_t             lse;
    logic               lse_first;
    smc_q_t             ll [3];
    smc_q_t             raw;
    smc_q_t             drop;
    smc_q_t             gcomb;
    smc_q_t             smooth;
    smc_q_t             hist [NHIST-1];
    logic signed [4:0]  st;
    logic [3:0]         cinact;
    logic [1:0]         fhist;

    // ---------------- register bus ----------------
    logic        bus_req;
    logic        wr_fire;
    logic        mem_hit;
    logic        feat_hit;
    logic        start_req;
    logic [31:0] rd_word;

    assign bus_req = i_wb_cyc & i_wb_stb;
    // partial-word writes are ignored; every field needs the full word
    assign wr_fire = bus_req & o_wb_ack & i_wb_we & (i_wb_sel == 4'hf);
    assign mem_hit = (i_wb_adr[15:14] == MEM_PAGE);
    assign feat_hit = (i_wb_adr[15:6] == FEAT_PAGE)
                   && (i_wb_adr[5:2] <= LAST_FEAT);
    assign start_req = wr_fire && (i_wb_adr == ADDR_CTRL)
                    && i_wb_dat[CTRL_START] && (phase == PH_IDLE);

    always_comb begin
        rd_word = 32'h0;
        if (mem_hit) begin
            rd_word = 32'(mem[i_wb_adr[13:2]]);
        end else if (feat_hit) begin
            rd_word = 32'(feat[i_wb_adr[5:2]]);
        end else begin
            case (i_wb_adr)
                ADDR_CTRL:   rd_word = {29'h0, hi_eff, wideband, 1'b0};
                ADDR_ENERGY: rd_word = 32'(energy);
                ADDR_STATUS: rd_word = {19'h0, st, 6'h0, o_music_flag,
                                        phase != PH_IDLE};
                ADDR_RAW:    rd_word = 32'(raw);
                ADDR_SMOOTH: rd_word = 32'(smooth);
                default:     rd_word = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= bus_req & ~o_wb_ack;
            o_wb_dat <= rd_word;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wideband <= CTRL_WIDE_RST;
            hi_eff <= 1'b0;
            energy <= '0;
            for (int k = 0; k < NFEAT; k++) begin
                feat[k] <= '0;
            end
        end else if (wr_fire) begin
            if (i_wb_adr == ADDR_CTRL) begin
                wideband <= i_wb_dat[CTRL_WIDE];
                hi_eff <= i_wb_dat[CTRL_HIEFF];
            end
            if (i_wb_adr == ADDR_ENERGY) begin
                energy <= i_wb_dat[W-1:0];
            end
            if (feat_hit) begin
                feat[i_wb_adr[5:2]] <= i_wb_dat[W-1:0];
            end
        end
    end

    // model store: per component 12 means, 144 precisions, 1 constant
    always_ff @(posedge i_clk) begin
        if (wr_fire && mem_hit) begin
            mem[i_wb_adr[13:2]] <= i_wb_dat[W-1:0];
        end
    end

    // ---------------- likelihood engine ----------------
    smc_q_t scaled [NFEAT];
    for (genvar g = 0; g < NFEAT; g++) begin : g_scale
        // features are latched into fs in the scale phase, so they may move after it
        assign scaled[g] = sat(mulq(wideband ? SFA_WB[g] : SFA_NB[g],
                                    feat[g])
                         + 64'(wideband ? SFB_WB[g] : SFB_NB[g]));
    end

    logic signed [63:0] tacc_next;
    logic signed [W:0]  gap_s;
    logic [W:0]         gap;
    smc_q_t             arg;
    smc_q_t             lse_next;
    smc_q_t             corr;

    always_comb begin
        tacc_next = tacc + mulq(mem[ptr], dvec[fj]);
        arg = sat(64'(mem[ptr]) - (qacc >>> 1));
        gap_s = {arg[W-1], arg} - {lse[W-1], lse};
        gap = gap_s[W] ? (W+1)'(-gap_s) : gap_s;
        // pairwise log-sum-exp: larger term plus a tabled correction
        corr = (gap >= LSE_SPAN) ? '0 : LSE_TAB[gap[13:11]];
        if (lse_first) begin
            lse_next = arg;
        end else begin
            lse_next = sat(64'(gap_s[W] ? lse : arg) + 64'(corr));
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            phase <= PH_IDLE;
            ci <= '0;
            ck <= '0;
            fi <= '0;
            fj <= '0;
            ptr <= '0;
            tacc <= '0;
            qacc <= '0;
            lse <= '0;
            lse_first <= 1'b1;
            for (int k = 0; k < NFEAT; k++) begin
                fs[k] <= '0;
                dvec[k] <= '0;
            end
            for (int k = 0; k < 3; k++) begin
                ll[k] <= '0;
            end
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (start_req) begin
                        phase <= PH_SCALE;
                    end
                end
                PH_SCALE: begin
                    fs <= scaled;
                    ptr <= '0;
                    ci <= '0;
                    ck <= '0;
                    fi <= '0;
                    lse_first <= 1'b1;
                    phase <= PH_MEAN;
                end
                PH_MEAN: begin
                    dvec[fi] <= sat(64'(fs[fi]) - 64'(mem[ptr]));
                    ptr <= ptr + 1'b1;
                    fi <= (fi == LAST_FEAT) ? '0 : fi + 1'b1;
                    if (fi == LAST_FEAT) begin
                        fj <= '0;
                        tacc <= '0;
                        qacc <= '0;
                        phase <= PH_PREC;
                    end
                end
                PH_PREC: begin
                    ptr <= ptr + 1'b1;
                    if (fj == LAST_FEAT) begin
                        fj <= '0;
                        tacc <= '0;
                        qacc <= qacc + mulq(dvec[fi], sat(tacc_next));
                        fi <= (fi == LAST_FEAT) ? '0 : fi + 1'b1;
                        if (fi == LAST_FEAT) begin
                            phase <= PH_CONST;
                        end
                    end else begin
                        fj <= fj + 1'b1;
                        tacc <= tacc_next;
                    end
                end
                PH_CONST: begin
                    ptr <= ptr + 1'b1;
                    lse <= lse_next;
                    lse_first <= 1'b0;
                    if (ck == LAST_COMP) begin
                        ck <= '0;
                        lse_first <= 1'b1;
                        ll[ci] <= sat(64'(lse_next) - HALF_LOG_2PI12);
                        ci <= ci + 1'b1;
                        phase <= (ci == LAST_CLASS) ? PH_RAW : PH_MEAN;
                    end else begin
                        ck <= ck + 1'b1;
                        phase <= PH_MEAN;
                    end
                end
                PH_RAW: phase <= PH_WEIGHT;
                PH_WEIGHT: phase <= PH_SMOOTH;
                PH_SMOOTH: phase <= PH_FLAG;
                PH_FLAG: phase <= PH_IDLE;
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // ---------------- decision and hangover ----------------
    smc_q_t             spch;
    smc_q_t             raw_next;
    smc_q_t             drop_next;
    smc_q_t             ge;
    smc_q_t             gd;
    smc_q_t             gc_next;
    smc_q_t             smooth_next;
    logic signed [4:0]  st_next;
    logic [3:0]         cinact_next;
    logic               low_energy;
    logic               flag_next;
    logic [2:0]         erow;
    smc_q_t             recent [NHIST];
    logic signed [63:0] eterm [NHIST];
    logic signed [63:0] entry_sum;

    assign erow = 3'(st[2:0] - 3'h1);
    assign recent[0] = raw;
    for (genvar g = 0; g < NHIST; g++) begin : g_entry
        if (g > 0) begin : g_old
            assign recent[g] = hist[g-1];
        end
        assign eterm[g] = mulq(smc_q_t'(ENTRY_G[{erow, 3'(g)}]),
                               recent[g]);
    end

    always_comb begin
        entry_sum = '0;
        for (int k = 0; k < NHIST; k++) begin
            entry_sum = entry_sum + eterm[k];
        end
    end

    always_comb begin
        spch = hi_eff ? ll[CLS_SPEECH]
                      : sat(mulq(ll[CLS_NOISE], NOISE_GAIN));
        raw_next = sat(64'(ll[CLS_MUSIC]) - 64'(spch));
        drop_next = '0;
        if (raw[W-1] && (raw < hist[0])) begin
            if (hist[0] > 0) begin
                drop_next = sat(64'sd0 - 64'(raw));
            end else begin
                drop_next = sat(64'(drop) + 64'(hist[0]) - 64'(raw));
            end
        end
        ge = sat(64'(ONE) + mulq(energy, INV15));
        if (ge < GE_MIN) ge = GE_MIN;
        if (ge > ONE) ge = ONE;
        gd = sat(mulq(drop_next, INV20));
        if (gd < GD_MIN) gd = GD_MIN;
        if (gd > ONE) gd = ONE;
        gc_next = sat(mulq(ge, gd));
        if (gc_next < GC_MIN) gc_next = GC_MIN;
    end

    // state steps; unsteady climbs back through entry, never straight up
    always_comb begin
        low_energy = (energy < ER_UNSTEADY);
        cinact_next = '0;
        st_next = st;
        if (!hi_eff) begin
            cinact_next = (cinact == CINACT_MAX) ? cinact : cinact + 1'b1;
            if ((cinact_next >= CINACT_LIMIT) || (st == ST_INACTIVE)) begin
                st_next = ST_INACTIVE;
            end else if (st > ST_ZERO) begin
                st_next = ST_ZERO;
            end else begin
                st_next = st - 1'b1;
            end
        end else if (st == ST_INACTIVE) begin
            st_next = ST_ENTRY;
        end else if (st == ST_ACTIVE) begin
            st_next = low_energy ? ST_ZERO : ST_ACTIVE;
        end else if (st > ST_ZERO) begin
            st_next = st + 1'b1;
        end else begin
            st_next = low_energy ? st - 1'b1 : st + 1'b1;
        end
        if (st_next == ST_INACTIVE) begin
            smooth_next = '0;
        end else begin
            smooth_next = sat(mulq(gcomb, raw)
                        + mulq(ONE - gcomb, smooth));
        end
    end

    always_comb begin
        flag_next = o_music_flag;
        if (st == ST_INACTIVE) begin
            if (!hi_eff) begin
                flag_next = 1'b0;
            end
        end else if ((st > ST_ZERO) && (st < ST_ACTIVE)) begin
            flag_next = (entry_sum > DEC_THRESH);
        end else if (st == ST_ACTIVE) begin
            if ((smooth > 0) && !o_music_flag && (fhist == 2'b00)) begin
                flag_next = 1'b1;
            end else if (smooth[W-1] && o_music_flag) begin
                flag_next = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            raw <= '0;
            drop <= '0;
            gcomb <= GC_MIN;
            smooth <= '0;
            st <= ST_INACTIVE;
            cinact <= '0;
            o_music_flag <= 1'b0;
            o_frame_done <= 1'b0;
            fhist <= '0;
            for (int k = 0; k < NHIST - 1; k++) begin
                hist[k] <= '0;
            end
        end else begin
            o_frame_done <= (phase == PH_FLAG);
            case (phase)
                PH_RAW: raw <= raw_next;
                PH_WEIGHT: begin
                    drop <= drop_next;
                    gcomb <= gc_next;
                end
                PH_SMOOTH: begin
                    st <= st_next;
                    cinact <= cinact_next;
                    smooth <= smooth_next;
                end
                PH_FLAG: begin
                    o_music_flag <= flag_next;
                    fhist <= {fhist[0], o_music_flag};
                    hist[0] <= raw;
                    for (int k = 1; k < NHIST - 1; k++) begin
                        hist[k] <= hist[k-1];
                    end
                end
                default: ;
            endcase
        end
    end

    // ---------------- assertions ----------------
    default clocking dcb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_go;
        phase == PH_IDLE && start_req;
    endsequence
    // twelve mean steps, written as two runs of six to keep unrolling small
    sequence s_front;
        phase == PH_SCALE ##1 phase == PH_MEAN [*6]
        ##1 phase == PH_MEAN [*6] ##1 phase == PH_PREC;
    endsequence

    a_frame_start: assert property (s_go |=> s_front)
        else $error("frame did not run scale then twelve means");
    a_state_range: assert property (
        st >= ST_INACTIVE && st <= ST_ACTIVE)
        else $error("state value out of range");
    a_active_entry: assert property (
        (st == ST_ACTIVE && $past(st) != ST_ACTIVE)
        |-> $past(st) == 5'sd7)
        else $error("active reached without entry");
    a_inactive_zero: assert property (
        st == ST_INACTIVE |-> smooth == 0)
        else $error("smoothed margin not zero when inactive");
    a_flag_clear: assert property (
        (phase == PH_FLAG && st == ST_INACTIVE && !hi_eff)
        |=> !o_music_flag && o_frame_done)
        else $error("flag not cleared when inactive");
    a_unsteady_hold: assert property (
        (phase == PH_FLAG && st <= ST_ZERO && st != ST_INACTIVE)
        |=> $stable(o_music_flag))
        else $error("flag moved in unsteady state");
    a_entry_flag: assert property (
        (phase == PH_FLAG && st > ST_ZERO && st < ST_ACTIVE)
        |=> o_music_flag == $past(entry_sum > DEC_THRESH))
        else $error("entry flag does not match entry sum");
    a_music_rise: assert property (
        (phase == PH_FLAG && st == ST_ACTIVE && smooth > 0
         && !o_music_flag && fhist == 2'b00) |=> o_music_flag)
        else $error("flag not set after three speech frames");
    a_music_fall: assert property (
        (phase == PH_FLAG && st == ST_ACTIVE && smooth[W-1]
         && o_music_flag) |=> !o_music_flag)
        else $error("flag not cleared on negative margin");
    a_drop_clear: assert property (
        (phase == PH_WEIGHT && !(raw[W-1] && raw < hist[0]))
        |=> drop == 0)
        else $error("drop accumulator not cleared");
    a_comb_floor: assert property (
        phase == PH_SMOOTH |-> gcomb >= GC_MIN && gcomb <= ONE)
        else $error("combined factor outside its bounds");
endmodule
`default_nettype wire

// ==== shared/smc_pkg.sv ====
// constants and types of the speech/music mixture classifier
package smc_pkg;
    localparam int W = 24;
    localparam int FRAC = 12;
    localparam int NFEAT = 12;
    localparam int NHIST = 8;
    localparam int BUS_AW = 16;
    localparam int MEM_AW = 12;
    localparam int MEM_WORDS = 4096;
    typedef logic signed [W-1:0] smc_q_t;
    typedef logic signed [15:0] smc_coef_t;
    typedef enum {PH_IDLE, PH_SCALE, PH_MEAN, PH_PREC, PH_CONST,
                  PH_RAW, PH_WEIGHT, PH_SMOOTH, PH_FLAG} smc_phase_t;
    localparam logic [3:0] LAST_FEAT = 4'hb;
    localparam logic [2:0] LAST_COMP = 3'h5;
    localparam logic [1:0] LAST_CLASS = 2'h2;
    localparam logic [1:0] CLS_SPEECH = 2'h0;
    localparam logic [1:0] CLS_MUSIC = 2'h1;
    localparam logic [1:0] CLS_NOISE = 2'h2;
    // byte addresses on the register bus
    localparam logic [15:0] ADDR_CTRL = 16'h0000;
    localparam logic [15:0] ADDR_ENERGY = 16'h0004;
    localparam logic [15:0] ADDR_STATUS = 16'h0008;
    localparam logic [15:0] ADDR_RAW = 16'h000c;
    localparam logic [15:0] ADDR_SMOOTH = 16'h0010;
    localparam logic [9:0] FEAT_PAGE = 10'h001;
    localparam logic [1:0] MEM_PAGE = 2'h1;
    localparam int CTRL_START = 0;
    localparam int CTRL_WIDE = 1;
    localparam int CTRL_HIEFF = 2;
    localparam logic CTRL_WIDE_RST = 1'h1;
    // Q12 fixed-point constants
    localparam logic signed [63:0] Q_MAX = 64'sh7fffff;
    localparam logic signed [63:0] Q_MIN = -64'sh800000;
    localparam smc_q_t ONE = 24'sh001000;
    localparam logic signed [63:0] HALF_LOG_2PI12 = 64'sd45167;
    localparam smc_q_t NOISE_GAIN = 24'sd4915;
    localparam smc_q_t INV15 = 24'sd273;
    localparam smc_q_t INV20 = 24'sd205;
    localparam smc_q_t GE_MIN = 24'sd41;
    localparam smc_q_t GD_MIN = 24'sd410;
    localparam smc_q_t GC_MIN = 24'sd41;
    localparam logic signed [63:0] DEC_THRESH = 64'sd8192;
    localparam smc_q_t ER_UNSTEADY = -24'sd40960;
    localparam logic [W:0] LSE_SPAN = 25'h004000;
    localparam smc_q_t LSE_TAB [8] = '{2839, 1942, 1283, 825, 520, 325,
                                      199, 123};
    localparam logic signed [4:0] ST_INACTIVE = -5'sd8;
    localparam logic signed [4:0] ST_ACTIVE = 5'sd8;
    localparam logic signed [4:0] ST_ZERO = 5'sd0;
    localparam logic signed [4:0] ST_ENTRY = 5'sd1;
    localparam logic [3:0] CINACT_LIMIT = 4'h5;
    localparam logic [3:0] CINACT_MAX = 4'hf;
    localparam smc_q_t SFA_WB [NFEAT] = '{197, 4097, 2550, 2252, 2033,
        2068, 2076, 17, 9, 258, 280, 475};
    localparam smc_q_t SFB_WB [NFEAT] = '{-390, 0, -285, -518, -913,
        -1681, -2342, 0, -12, 4102, 3729, -1201};
    localparam smc_q_t SFA_NB [NFEAT] = '{17, 3511, 2760, 2563, 2251,
        2373, 1025, 17, 8, 258, 245, 258};
    localparam smc_q_t SFB_NB [NFEAT] = '{0, 418, -410, -687, -975,
        -1903, 0, 0, 0, 4102, 3673, 0};
    localparam smc_coef_t ENTRY_G [64] = '{
        4096, 0, 0, 0, 0, 0, 0, 0,
        2458, 1638, 0, 0, 0, 0, 0, 0,
        1925, 1352, 819, 0, 0, 0, 0, 0,
        1638, 1229, 819, 410, 0, 0, 0, 0,
        1229, 1024, 819, 614, 410, 0, 0, 0,
        954, 848, 737, 627, 520, 410, 0, 0,
        963, 840, 713, 586, 459, 332, 205, 0,
        819, 733, 643, 557, 467, 381, 291, 205};
endpackage

// ==== bench/smc_feed_model.sv ====
// stand-in for the upstream feature extractor
`timescale 1ns/1ps
`default_nettype none
module smc_feed_model (
    input  wire logic [3:0]  i_feat,
    input  wire logic [3:0]  i_frame,
    output logic      [31:0] o_word
);
    // pure function of frame and index: it holds still while a frame runs
    assign o_word = {20'h0, i_frame, i_feat, 4'h0};
endmodule
`default_nettype wire

// ==== bench/test_smc_classifier.sv ====
// self-checking bench for the speech/music classifier
`timescale 1ns/1ps
`default_nettype none
module test_smc_classifier;
    import smc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [15:0] adr = 16'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd;
    logic        ack;
    logic        flag;
    logic        done;
    logic [3:0]  fi = 4'h0;
    logic [3:0]  fr = 4'h0;
    logic [31:0] feat;
    int          n_mismatch = 0;
    int          checks = 0;
    smc_classifier smc_classifier_i (.i_clk(clk), .i_reset(rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack),
        .o_music_flag(flag), .o_frame_done(done));
    smc_feed_model smc_feed_model_i (.i_feat(fi), .i_frame(fr),
        .o_word(feat));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] s,
                      input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= s;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            n_mismatch++;
            end_sim;
        end
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic frame(input logic he, input logic [4:0] st,
                         input logic fl);
        logic [31:0] q;
        int n;
        for (int i = 0; i < 12; i++) begin
            fi <= i[3:0];
            @(posedge clk);
            wb(1'b1, 4'hf, 16'h0040 + 16'(4 * i), feat, q);
        end
        wb(1'b1, 4'hf, ADDR_CTRL, {29'h0, he, 2'b11}, q);
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (done !== 1'b1) begin
            n_mismatch++;
            end_sim;
        end
        chk({31'h0, flag}, {31'h0, fl});
        wb(1'b0, 4'hf, ADDR_STATUS, 32'h0, q);
        chk(q, {19'h0, st, 6'h0, fl, 1'b0});
        fr <= fr + 4'h1;
    endtask
    task automatic t_reset;
        logic [31:0] q;
        wb(1'b0, 4'hf, ADDR_STATUS, 32'h0, q);
        chk(q, 32'h1800);
        wb(1'b0, 4'hf, ADDR_CTRL, 32'h0, q);
        chk(q, 32'h2);
    endtask
    task automatic t_refuse;
        logic [31:0] q;
        wb(1'b1, 4'h3, ADDR_ENERGY, 32'h123, q);
        wb(1'b1, 4'hf, ADDR_STATUS, 32'hffff, q);
        wb(1'b0, 4'hf, ADDR_ENERGY, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, 4'hf, 16'h0020, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b0, 4'hf, ADDR_STATUS, 32'h0, q);
        chk(q, 32'h1800);
        wb(1'b1, 4'hf, ADDR_CTRL, 32'h4, q);
        wb(1'b0, 4'hf, ADDR_CTRL, 32'h0, q);
        chk(q, 32'h4);
    endtask
    // zero model, music constants at 5.0: music wins by a known margin
    task automatic t_load;
        logic [31:0] q;
        for (int n = 0; n < 2826; n++) begin
            wb(1'b1, 4'hf, 16'h4000 + 16'(4 * n),
               (n / 157 > 5 && n / 157 < 12 && n % 157 == 156)
               ? 32'h5000 : 32'h0, q);
        end
    endtask
    // rewrites the constant word of each of the six music components
    task automatic set_music(input logic [31:0] c);
        logic [31:0] q;
        for (int k = 6; k < 12; k++) begin
            wb(1'b1, 4'hf, 16'h4000 + 16'(4 * (k * 157 + 156)), c, q);
        end
    endtask
    // active state: music at -5.0 drags the flag down after the drop
    // boost, then three speech frames and +5.0 raise it again
    task automatic t_swing;
        logic [31:0] q;
        set_music(32'h00ffb000);
        frame(1'b1, 5'h8, 1'b1);
        wb(1'b0, 4'hf, ADDR_RAW, 32'h0, q);
        chk(q, 32'hffffb000);
        wb(1'b0, 4'hf, ADDR_SMOOTH, 32'h0, q);
        chk({31'h0, $signed(q) > 3000 && $signed(q) < 4200}, 32'h1);
        frame(1'b1, 5'h8, 1'b1);
        frame(1'b1, 5'h8, 1'b0);
        set_music(32'h5000);
        frame(1'b1, 5'h8, 1'b0);
        frame(1'b1, 5'h8, 1'b0);
        frame(1'b1, 5'h8, 1'b1);
    endtask
    task automatic t_run;
        logic [31:0] q;
        frame(1'b0, 5'h18, 1'b0);
        wb(1'b0, 4'hf, ADDR_RAW, 32'h0, q);
        chk({31'h0, $signed(q) > 0}, 32'h1);
        wb(1'b0, 4'hf, ADDR_SMOOTH, 32'h0, q);
        chk(q, 32'h0);
        frame(1'b1, 5'h1, 1'b1);
        wb(1'b0, 4'hf, ADDR_SMOOTH, 32'h0, q);
        chk({31'h0, $signed(q) > 1900 && $signed(q) < 2200}, 32'h1);
        for (int k = 2; k <= 8; k++) begin
            frame(1'b1, 5'(k), 1'b1);
        end
        t_swing;
        frame(1'b0, 5'h0, 1'b1);
        for (int k = 1; k <= 3; k++) begin
            frame(1'b0, 5'(-k), 1'b1);
        end
        frame(1'b0, 5'h18, 1'b0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_refuse;
        t_load;
        t_run;
        end_sim;
    end
endmodule
`default_nettype wire
